/* rtl/sbuf_pkg.sv */
// Purpose: Shared constants, types and arithmetic for the chained sample buffer averager.
// Assumes: 16-bit samples, four buffers of up to eight words, APB with an 8-bit byte address.
// Notes:   Register offsets are byte addresses; every register is one aligned 32-bit word.
`default_nettype none

package sbuf_pkg;

	// Geometry
	localparam int NBUF  = 4;
	localparam int DEPTH = 8;
	localparam int DW    = 16;
	localparam int SUMW  = 19;   // Eight full-scale words fit without overflow
	localparam int AW    = 8;

	// Register byte offsets
	localparam logic [AW-1:0] OFS_CFG0   = 8'h00;  // Four config registers, stride 4
	localparam logic [AW-1:0] OFS_STATUS = 8'h10;
	localparam logic [AW-1:0] OFS_MASK   = 8'h14;
	localparam logic [AW-1:0] OFS_SAMPLE = 8'h18;
	localparam logic [AW-1:0] OFS_RES0   = 8'h20;  // Four result registers, stride 4
	localparam logic [AW-1:0] OFS_WORDS  = 8'h40;  // Word windows, 0x20 per buffer
	localparam logic [AW-1:0] OFS_WEND   = 8'hBC;

	// Status and mask layout
	localparam int ST_RDY_LSB = 0;
	localparam int ST_OVF_LSB = 4;
	localparam int ST_ERR_LSB = 8;
	localparam int STW        = 12;

	// Reset values
	localparam logic [STW-1:0] STATUS_RST = 12'h000;
	localparam logic [STW-1:0] MASK_RST   = 12'h000;
	localparam logic [7:0]     CFG_RST    = 8'h00;

	// Oversampling lengths, stored as length minus one
	localparam logic [2:0] OVS_LEN4_M1 = 3'h3;
	localparam logic [2:0] OVS_LEN8_M1 = 3'h7;

	typedef enum logic [1:0] {
		MODE_STORE,
		MODE_MAVG,
		MODE_OVS,
		MODE_SPARE
	} mode_t;

	// Config register image: bits [1:0] mode, [4:2] length-1, 5 chain, 6 halt, 7 enable
	typedef struct packed {
		logic       en;
		logic       halt;
		logic       chain;
		logic [2:0] len_m1;
		mode_t      mode;
	} cfg_t;

	// Mean of the held samples; n is never zero
	function automatic logic [DW-1:0] mean_of(input logic [SUMW-1:0] s, input logic [3:0] n);
		logic [SUMW-1:0] q;
		q = s / {{(SUMW-4){1'b0}}, n};
		return q[DW-1:0];
	endfunction : mean_of

	// Oversampling scale: four words shift by one, eight by two, saturating at full scale
	function automatic logic [DW-1:0] ovs_scale(input logic [SUMW-1:0] s, input logic [2:0] len_m1);
		logic [SUMW-1:0] q;
		q = (len_m1 == OVS_LEN8_M1) ? (s >> 2) : (s >> 1);
		return (q[SUMW-1:DW] != '0) ? 16'hFFFF : q[DW-1:0];
	endfunction : ovs_scale

endpackage : sbuf_pkg

`default_nettype wire

/* rtl/sbuf_stage.sv */
// Purpose: One sample buffer: storage, moving average or oversampling.
// Assumes: Load and data come from logic on pclk; cfg is stable except across a flush.
// Notes:   Word 0 is the newest sample; the oldest held word sits at index count-1.
`default_nettype none

module sbuf_stage
	import sbuf_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire cfg_t              cfg,
	input  wire logic              flush,
	input  wire logic              load,
	input  wire logic [DW-1:0]     din,
	input  wire logic [2:0]        rd_idx,
	output logic      [DW-1:0]     rd_word,
	output logic      [DW-1:0]     result,
	output logic                   rdy,
	output logic                   ovf,
	output logic      [3:0]        count
);

	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] mem;
		logic [3:0]               count;
		logic [2:0]               decim;
		logic [SUMW-1:0]          sum;
		logic [DW-1:0]            result;
		logic                     rdy;
		logic                     ovf;
	} stage_st_t;

	stage_st_t                st_r;
	stage_st_t                st_nxt;
	logic [3:0]               len;
	logic                     full;
	logic [DW-1:0]            evict;
	logic [DEPTH-1:0][DW-1:0] shifted;
	logic [SUMW-1:0]          sum_mv;
	logic [SUMW-1:0]          sum_ov;
	logic [3:0]               cnt_inc;

	// Next state; the shift register keeps the window without read or write pointers
	always_comb begin
		len     = {1'b0, cfg.len_m1} + 4'h1;
		full    = (st_r.count == len);
		evict   = st_r.mem[cfg.len_m1];
		shifted = {st_r.mem[DEPTH-2:0], din};
		cnt_inc = full ? st_r.count : st_r.count + 4'h1;
		sum_mv  = st_r.sum + {3'b000, din} - (full ? {3'b000, evict} : {SUMW{1'b0}});
		sum_ov  = st_r.sum + {3'b000, din};
		st_nxt      = st_r;
		st_nxt.rdy  = 1'b0;
		st_nxt.ovf  = 1'b0;
		if (flush) begin
			st_nxt = '0;
		end else if (load && cfg.en) begin                 // [RQ15]
			case (cfg.mode)
				MODE_STORE: begin
					st_nxt.ovf = full;                          // [RQ14]
					if (!(full && cfg.halt)) begin             // [RQ14]
						st_nxt.mem   = shifted;                  // [RQ2]
						st_nxt.count = cnt_inc;
						if (full) begin
							st_nxt.result = evict;               // [RQ2] [RQ3]
							st_nxt.rdy    = 1'b1;                // [RQ15]
						end
					end
				end
				MODE_MAVG: begin
					st_nxt.mem    = shifted;
					st_nxt.count  = cnt_inc;
					st_nxt.sum    = sum_mv;
					st_nxt.result = mean_of(sum_mv, cnt_inc);   // [RQ6]
					// Ready only once per window, so a chained stage decimates
					if (st_r.decim == cfg.len_m1) begin
						st_nxt.decim = 3'h0;
						st_nxt.rdy   = 1'b1;                     // [RQ8] [RQ7]
					end else begin
						st_nxt.decim = st_r.decim + 3'h1;
					end
				end
				MODE_OVS: begin
					st_nxt.mem   = shifted;
					st_nxt.count = cnt_inc;
					if (st_r.decim == cfg.len_m1) begin
						st_nxt.result = ovs_scale(sum_ov, cfg.len_m1); // [RQ11] [RQ12] [RQ9]
						st_nxt.rdy    = 1'b1;
						st_nxt.sum    = '0;
						st_nxt.decim  = 3'h0;
					end else begin
						st_nxt.sum   = sum_ov;
						st_nxt.decim = st_r.decim + 3'h1;
					end
				end
				default: begin
					st_nxt.ovf = 1'b0;                          // Spare mode loads nothing
				end
			endcase
		end
	end

	// State register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign rd_word = st_r.mem[rd_idx];
	assign result  = st_r.result;
	assign rdy     = st_r.rdy;
	assign ovf     = st_r.ovf;
	assign count   = st_r.count;

endmodule : sbuf_stage

`default_nettype wire

/* rtl/sbuf_top.sv */
// Purpose: Four chainable sample buffers with an APB register file and a masked interrupt.
// Assumes: sample_load and sample_in come from the ADC result path on pclk, so no synchroniser.
// Notes:   APB answers with one wait state; pready rises in the second access cycle.
//
// Functional notes
// RQ1: Four eight-word sixteen-bit buffers, three modes
// RQ2: Storage mode: FIFO, new word replaces oldest
// RQ3: Chaining extends depth from eight to thirty-two
// RQ4: Chained output feeds next buffer input internally
// RQ5: Previous ready strobe drives next load directly
// RQ6: Moving average: mean of last N, each load
// RQ7: Four chained averagers reach 4096 equivalent samples
// RQ8: Chained averager loads next every length loads
// RQ9: Each oversampling stage adds one resolution bit
// RQ10: Oversampling only with length four or eight
// RQ11: Four-word oversampling: sum of four, halved
// RQ12: Eight-word oversampling: sum of eight, quartered
// RQ13: Oversampling stages chain over internal connections
// RQ14: Host reads results; overflow interrupts or halts
// RQ15: Capture on load; one-cycle ready per result
`default_nettype none

module sbuf_top
	import sbuf_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          ce,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          sample_load,
	input  wire logic [DW-1:0] sample_in,
	output logic               irq,
	output logic      [DW-1:0] chain_result,
	output logic               chain_ready
);

	typedef struct packed {
		cfg_t [NBUF-1:0] cfg;
		logic [STW-1:0]  status;
		logic [STW-1:0]  mask;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
		logic            irq;
		logic [NBUF-1:0] flush;
		logic            sw_load;
		logic [DW-1:0]   sw_data;
	} top_st_t;

	top_st_t                   st_r;
	top_st_t                   st_nxt;

	// Per-buffer wiring between the register file and the stages
	logic    [NBUF-1:0]        ld;
	logic    [NBUF-1:0][DW-1:0] din;
	logic    [NBUF-1:0][DW-1:0] rd_word;
	logic    [NBUF-1:0][DW-1:0] result;
	logic    [NBUF-1:0]        rdy;
	logic    [NBUF-1:0]        ovf;
	logic    [NBUF-1:0][3:0]   count;

	// Bus decode helpers
	logic                      acc_first;
	logic                      done;
	logic                      wr_done;
	logic                      rd_done;
	logic                      hit;
	logic    [31:0]            rdata;
	logic    [STW-1:0]         events;
	logic    [NBUF-1:0]        cfg_err;
	logic    [1:0]             sel;
	logic    [1:0]             wsel;
	cfg_t                      wcfg;

	// Config write check: oversampling is refused unless the length is four or eight
	function automatic logic cfg_ok(input cfg_t c);
		return (c.mode != MODE_OVS) || (c.len_m1 == OVS_LEN4_M1) || (c.len_m1 == OVS_LEN8_M1);
	endfunction : cfg_ok

	// Buffer index from a register offset inside a stride-4 group
	function automatic logic [1:0] grp_idx(input logic [AW-1:0] a, input logic [AW-1:0] base);
		logic [AW-1:0] d;
		d = a - base;
		return d[3:2];
	endfunction : grp_idx

	// Chain routing: a chained buffer takes the previous stage's result and ready strobe,
	// never the sample path, so a chain needs no outside routing.
	always_comb begin
		for (int i = 0; i < NBUF; i++) begin
			if ((i > 0) && st_r.cfg[i].chain) begin
				ld[i]  = rdy[(i > 0) ? i - 1 : 0];                 // [RQ5] [RQ13]
				din[i] = result[(i > 0) ? i - 1 : 0];              // [RQ4] [RQ3] [RQ13]
			end else begin
				ld[i]  = sample_load | st_r.sw_load;
				din[i] = sample_load ? sample_in : st_r.sw_data;
			end
		end
	end

	// Four identical stages, each configured on its own
	for (genvar g = 0; g < NBUF; g++) begin : g_buf
		sbuf_stage u_stage (                                        // [RQ1]
			.pclk    (pclk),
			.presetn (presetn),
			.ce      (ce),
			.cfg     (st_r.cfg[g]),
			.flush   (st_r.flush[g]),
			.load    (ld[g]),
			.din     (din[g]),
			.rd_idx  (paddr[4:2]),
			.rd_word (rd_word[g]),
			.result  (result[g]),
			.rdy     (rdy[g]),
			.ovf     (ovf[g]),
			.count   (count[g])
		);
	end

	// APB phase tracking: one wait state, then the transfer completes
	always_comb begin
		acc_first = psel && penable && !st_r.pready;
		done      = psel && penable && st_r.pready;
		wr_done   = done && pwrite;
		rd_done   = done && !pwrite;
		wcfg      = cfg_t'(pwdata[7:0]);
	end

	// Read mux and address hit; unaligned or unmapped addresses raise pslverr
	always_comb begin
		rdata = 32'h0000_0000;
		hit   = 1'b0;
		sel   = 2'b00;
		if (paddr[1:0] != 2'b00) begin
			hit = 1'b0;
		end else if (paddr < OFS_STATUS) begin
			sel   = grp_idx(paddr, OFS_CFG0);
			hit   = 1'b1;
			rdata = {24'h00_0000, st_r.cfg[sel]};
		end else if (paddr == OFS_STATUS) begin
			hit   = 1'b1;
			rdata = {20'h0_0000, st_r.status};
		end else if (paddr == OFS_MASK) begin
			hit   = 1'b1;
			rdata = {20'h0_0000, st_r.mask};
		end else if (paddr == OFS_SAMPLE) begin
			hit   = 1'b1;
			rdata = {16'h0000, st_r.sw_data};
		end else if ((paddr >= OFS_RES0) && (paddr < OFS_WORDS) && (paddr < OFS_RES0 + 8'h10)) begin
			sel   = grp_idx(paddr, OFS_RES0);
			hit   = 1'b1;
			rdata = {12'h000, count[sel], result[sel]};              // [RQ14]
		end else if ((paddr >= OFS_WORDS) && (paddr <= OFS_WEND)) begin
			sel   = paddr[6:5] - 2'b10;
			hit   = 1'b1;
			rdata = {16'h0000, rd_word[sel]};                      // [RQ14]
		end
	end

	// Hardware events for the sticky status register
	always_comb begin
		cfg_err = '0;
		for (int i = 0; i < NBUF; i++) begin
			if (wr_done && (paddr == OFS_CFG0 + AW'(4 * i)) && !cfg_ok(wcfg)) begin
				cfg_err[i] = 1'b1;                                  // [RQ10]
			end
		end
		events = {cfg_err, ovf, rdy};                            // [RQ14]
	end

	// Register file and bus answer
	always_comb begin
		wsel           = 2'b00;
		st_nxt         = st_r;
		st_nxt.flush   = '0;
		st_nxt.sw_load = 1'b0;
		// Answer is prepared in the first access cycle and held through the completing edge
		if (acc_first) begin
			st_nxt.pready  = 1'b1;
			st_nxt.prdata  = pwrite ? 32'h0000_0000 : rdata;
			st_nxt.pslverr = !hit;
		end else if (done) begin
			st_nxt.pready  = 1'b0;
			st_nxt.pslverr = 1'b0;
			st_nxt.prdata  = 32'h0000_0000;
		end
		// Writes land only at the completing edge
		if (wr_done && hit) begin
			if (paddr < OFS_STATUS) begin
				// Own index here, so the read mux keeps sole ownership of sel
				wsel = grp_idx(paddr, OFS_CFG0);
				if (cfg_ok(wcfg)) begin                             // [RQ10]
					st_nxt.cfg[wsel]       = wcfg;
					st_nxt.cfg[wsel].chain = (wsel != 2'b00) && wcfg.chain;
					st_nxt.flush[wsel]     = 1'b1;  // Restart the window on any reconfigure
				end
			end else if (paddr == OFS_MASK) begin
				st_nxt.mask = pwdata[STW-1:0];
			end else if (paddr == OFS_SAMPLE) begin
				// A pin load in the same cycle takes precedence over this one
				st_nxt.sw_data = pwdata[DW-1:0];
				st_nxt.sw_load = 1'b1;
			end
		end
		// Read of status clears it, but an event in the same cycle survives
		if (rd_done && (paddr == OFS_STATUS)) begin
			st_nxt.status = events;
		end else begin
			st_nxt.status = st_r.status | events;
		end
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);               // [RQ14]
	end

	// State register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r        <= '0;
			st_r.status <= STATUS_RST;
			st_r.mask   <= MASK_RST;
			st_r.cfg    <= {NBUF{CFG_RST}};
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign prdata       = st_r.prdata;
	assign pready       = st_r.pready;
	assign pslverr      = st_r.pslverr;
	assign irq          = st_r.irq;
	assign chain_result = result[NBUF-1];
	assign chain_ready  = rdy[NBUF-1];

endmodule : sbuf_top

`default_nettype wire

/* dv/sbuf_props.sv */
// Purpose: Port-level assertions for the chained sample buffer block
// Assumes: One clock domain on pclk, asynchronous active-low presetn
// Notes:   Sees only the top ports; bound at the foot of this file
`default_nettype none

module sbuf_props
	import sbuf_pkg::*;
(
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic          ce,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	input wire logic          irq,
	input wire logic [DW-1:0] chain_result,
	input wire logic          chain_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Bus answer timing: one wait state, one-cycle answer, nothing unasked
	wait_state_a: assert property (psel && penable && !pready && ce |=> pready) else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	idle_quiet_a: assert property (!(psel && penable) |=> !pready) else $error("pready unasked");
	err_qual_a: assert property (pslverr |-> pready) else $error("pslverr alone");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata stale");
	unaligned_err_a: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr) else $error("unaligned taken");
	// A stopped clock enable must not let a result slip through
	freeze_result_a: assert property (!ce |=> $stable(chain_result)) else $error("result moved");
	reset_quiet_a: assert property ($rose(presetn) |-> !irq && !pready && !chain_ready) else $error("not quiet");

	cover property (pready && pslverr);
	cover property (chain_ready);
	cover property ($rose(irq));
endmodule : sbuf_props

bind sbuf_top sbuf_props u_props (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.chain_result(chain_result), .chain_ready(chain_ready)
);

`default_nettype wire

/* dv/adc_src.sv */
// Purpose: Conversion result source feeding the sample port
// Assumes: Bench asks for a word with fire one cycle ahead
// Notes:   Data lines toggle between words so stale data never looks valid
`default_nettype none

module adc_src
	import sbuf_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          fire,
	input  wire logic [DW-1:0] val,
	output logic               sample_load,
	output logic      [DW-1:0] sample_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// One-cycle load strobe per word; idle data inverts every cycle, starting from the last word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_load <= 1'b0;
			sample_in   <= 16'h0000;
		end else begin
			sample_load <= fire;
			sample_in   <= fire ? val : ~sample_in;
		end
	end
endmodule : adc_src

`default_nettype wire

/* dv/chained_sample_buffer_averager_tb.sv */
// Purpose: Self-checking bench for the chained sample buffers
// Assumes: APB master on pclk, result source model on the sample port
// Notes:   Random words from a fixed xorshift seed, first word of each burst is full scale
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp=%h got=%h", nm, e, g); end end

module chained_sample_buffer_averager_tb
	import sbuf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
	logic [AW-1:0] paddr = '0;
	logic [31:0]   pwdata = '0, prdata, rd, seed = 32'd35283;
	logic pready, pslverr, irq, chain_ready, sample_load, er;
	logic [DW-1:0] sample_in, chain_result, val = '0, got[$], smp[$];
	logic [18:0]   sum;
	int            err_count = 0, check_count = 0;
	logic [7:0]    ra[5] = '{8'h00, 8'h10, 8'h14, 8'hfc, 8'h11};
	logic [7:0]    cfgs[3] = '{8'h8e, 8'h9e, 8'h8d};
	int            lens[3] = '{4, 8, 4};

	always #25 pclk = ~pclk;

	sbuf_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_load(sample_load), .sample_in(sample_in), .irq(irq), .chain_result(chain_result),
		.chain_ready(chain_ready));
	adc_src u_src (.pclk(pclk), .presetn(presetn), .fire(fire), .val(val), .sample_load(sample_load),
		.sample_in(sample_in));

	// Collect every result that the last buffer announces
	always @(posedge pclk) if (chain_ready === 1'b1) got.push_back(chain_result);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Expected output: k 0 halves, 1 quarters (both saturate), 2 takes a four-word mean
	function automatic logic [DW-1:0] expv(input int k, input logic [18:0] s);
		logic [18:0] q;
		q = (k == 2) ? s / 19'd4 : (k == 1) ? s >> 2 : s >> 1;
		if (k != 2 && q[18:16] != 3'b000) q = 19'h0_ffff;
		return q[15:0];
	endfunction : expv

	task results();
		if (err_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results

	// One APB transfer; request held until pready is seen at an edge
	task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && i < 20) begin
			i++;
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (i >= 20) begin
			err_count++;
			results();
		end
	endtask : apb

	// Back-to-back sample burst, then time for the chain to ripple
	task lds(input int n);
		logic [DW-1:0] v;
		smp.delete();
		sum = '0;
		for (int i = 0; i < n; i++) begin
			v = (i == 0) ? 16'hffff : 16'(xs());
			smp.push_back(v);
			sum = sum + 19'(v);
			fire <= 1'b1;
			val <= v;
			@(posedge pclk);
		end
		fire <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask : lds

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values, then refused addresses
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ra[i], 32'h0, rd, er);
			`CHK("rdata", 32'h0000_0000, rd)
			`CHK("slverr", (i >= 3), er)
		end
		// Last buffer alone in each arithmetic mode
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, 8'h0c, {24'h0, cfgs[k]}, rd, er);
			apb(1'b0, 8'h0c, 32'h0, rd, er);
			`CHK("cfg", {24'h0, cfgs[k]}, rd)
			got.delete();
			lds(lens[k]);
			`CHK("rdy count", 1, got.size())
			`CHK("result", expv(k, sum), got[0])
		end
		// Oversampling with length three is refused and flagged
		apb(1'b0, OFS_STATUS, 32'h0, rd, er);
		apb(1'b1, 8'h0c, 32'h0000_008a, rd, er);
		apb(1'b0, 8'h0c, 32'h0, rd, er);
		`CHK("kept cfg", 32'h0000_008d, rd)
		apb(1'b0, OFS_STATUS, 32'h0, rd, er);
		`CHK("reject flag", 32'h0000_0800, rd)
		ce <= 1'b0;
		repeat (3) @(posedge pclk);
		ce <= 1'b1;
		// Four storage buffers chained: thirty-two words deep, overflow raises irq
		apb(1'b1, OFS_MASK, 32'h0000_0080, rd, er);
		apb(1'b1, 8'h00, 32'h0000_009c, rd, er);
		for (int b = 1; b < 4; b++) apb(1'b1, 8'(4 * b), 32'h0000_00bc, rd, er);
		apb(1'b0, OFS_STATUS, 32'h0, rd, er);
		got.delete();
		lds(34);
		`CHK("chain depth", 2, got.size())
		`CHK("chain word0", smp[0], got[0])
		`CHK("chain word1", smp[1], got[1])
		`CHK("irq", 1'b1, irq)
		apb(1'b0, OFS_STATUS, 32'h0, rd, er);
		`CHK("overflow", 1'b1, rd[7])
		repeat (2) @(posedge pclk);
		`CHK("irq clear", 1'b0, irq)
		// Host view of the chain: result register and held-word windows
		apb(1'b0, 8'h2c, 32'h0, rd, er);
		`CHK("result reg", {12'h000, 4'h8, smp[1]}, rd)
		apb(1'b0, 8'h40, 32'h0, rd, er);
		`CHK("buf0 newest", {16'h0000, smp[33]}, rd)
		apb(1'b0, 8'h5c, 32'h0, rd, er);
		`CHK("buf0 oldest", {16'h0000, smp[26]}, rd)
		apb(1'b0, 8'ha0, 32'h0, rd, er);
		`CHK("buf3 newest", {16'h0000, smp[9]}, rd)
		// Register-driven sample ripples one word out of the full chain
		got.delete();
		apb(1'b1, OFS_SAMPLE, 32'h0000_1234, rd, er);
		repeat (8) @(posedge pclk);
		`CHK("sw rdy count", 1, got.size())
		`CHK("sw evict", smp[2], got[0])
		`CHK("sw irq", 1'b1, irq)
		apb(1'b0, OFS_SAMPLE, 32'h0, rd, er);
		`CHK("sample reg", 32'h0000_1234, rd)
		apb(1'b0, 8'h40, 32'h0, rd, er);
		`CHK("sw newest", 32'h0000_1234, rd)
		results();
	end
endmodule : chained_sample_buffer_averager_tb

`default_nettype wire
